// *** rtl/subclock_interval_prescaler.sv ***
// Subclock interval prescaler: counter, tap select, flag, APB registers
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps

module subclock_interval_prescaler (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Subclock and system mode inputs
  input  wire logic         sub_osc_tick,
  input  wire logic         main_stop_mode,
  input  wire logic         deep_halt_request,
  input  wire logic         sub_clock_mode,
  input  wire logic         dog_reset_req,
  input  wire logic         dog_clk_sel,
  // Outputs
  output logic              tick_vector_line,
  output logic              irq,
  output logic              dog_count_clk,
  output logic              dog_counter_clear,
  output logic              osc_wait_active,
  output logic              cpu_reset_out,
  output logic              main_mode_restart
);

  // Bus decode
  logic                          setup_ph;     // Setup cycle
  logic                          wr_acc;       // Write access edge
  logic                          rd_acc;       // Read access edge
  logic                          mapped;       // Address hits a register
  logic                          wr_ctrl;      // Control write
  logic                          wr_mask;      // Mask write
  logic                          rd_status;    // Status read edge
  // Control state
  logic                          flag_q;       // Interval flag
  logic                          en_q;         // Interrupt enable
  logic [2:0]                    sel_q;        // Interval select
  logic                          flag_set;     // Qualified tap fall
  // Counter
  logic [sprescale_pkg::CNT_W-1:0] count_q;
  logic [sprescale_pkg::CNT_W-1:0] bit_fall;
  logic                          tap_fall;     // Selected tap falls
  logic                          sw_clear;     // Software clear
  logic                          halt_prev_q;  // Last halt request
  logic                          halt_rise;    // Sub-stop entry
  logic                          dog_sub_rst;  // Dog reset in sub mode
  logic                          clear_any;    // Any counter clear
  // Wait sequencer
  sprescale_pkg::wait_state_t    state_q;
  sprescale_pkg::wait_state_t    state_d;
  logic                          stab_fall;
  // Events
  logic [sprescale_pkg::EVT_W-1:0] status_q;
  logic [sprescale_pkg::EVT_W-1:0] mask_q;
  logic [sprescale_pkg::EVT_W-1:0] evt_set;
  logic [sprescale_pkg::EVT_W-1:0] rd_taken_q;  // Bits shown on read
  logic [31:0]                   rdata_d;
  logic [31:0]                   prdata_q;

  // Access decode; zero wait states so pready stays high
  assign setup_ph  = psel && !penable;
  assign wr_acc    = psel && penable && pwrite;
  assign rd_acc    = psel && penable && !pwrite;
  assign mapped    = (paddr == sprescale_pkg::ADDR_CTRL)
                  || (paddr == sprescale_pkg::ADDR_STATUS)
                  || (paddr == sprescale_pkg::ADDR_MASK)
                  || (paddr == sprescale_pkg::ADDR_COUNT);
  assign wr_ctrl   = wr_acc && (paddr == sprescale_pkg::ADDR_CTRL);
  assign wr_mask   = wr_acc && (paddr == sprescale_pkg::ADDR_MASK);
  assign rd_status = rd_acc && (paddr == sprescale_pkg::ADDR_STATUS);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;
  assign prdata    = prdata_q;

  // Software clear is a control write with the clear bit at zero
  assign sw_clear  = wr_ctrl && !pwdata[sprescale_pkg::CLR_BIT];
  assign halt_rise = deep_halt_request && !halt_prev_q;
  assign dog_sub_rst = dog_reset_req && sub_clock_mode;
  assign clear_any = sw_clear || halt_rise || dog_sub_rst;

  // Counter core
  subclock_counter #(
    .W        (sprescale_pkg::CNT_W)
  ) u_counter (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .tick     (sub_osc_tick),
    .clear    (clear_any),
    .count_q  (count_q),
    .bit_fall (bit_fall)
  );

  // Tap selector; unused codes fall back to the longest tap
  always_comb
  begin
    case (sel_q)
      sprescale_pkg::SEL_P10: tap_fall = bit_fall[sprescale_pkg::TAP_10];
      sprescale_pkg::SEL_P13: tap_fall = bit_fall[sprescale_pkg::TAP_13];
      sprescale_pkg::SEL_P14: tap_fall = bit_fall[sprescale_pkg::TAP_14];
      sprescale_pkg::SEL_P15: tap_fall = bit_fall[sprescale_pkg::TAP_15];
      sprescale_pkg::SEL_P16: tap_fall = bit_fall[sprescale_pkg::TAP_16];
      default:                tap_fall = bit_fall[sprescale_pkg::TAP_17];
    endcase
  end

  // Flag sets on tap falls except in main stop mode
  assign flag_set = tap_fall && !main_stop_mode;

  // Interval flag: hardware set wins over a software clear
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      flag_q <= 1'b0;
    end
    else if (flag_set)
    begin
      flag_q <= 1'b1;
    end
    else if (wr_ctrl && !pwdata[sprescale_pkg::FLAG_BIT])
    begin
      flag_q <= 1'b0;
    end
  end

  // Enable and interval select, written with the control word
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      en_q  <= sprescale_pkg::EN_RST;
      sel_q <= sprescale_pkg::SEL_RST;
    end
    else if (wr_ctrl)
    begin
      en_q  <= pwdata[sprescale_pkg::EN_BIT];
      sel_q <= pwdata[sprescale_pkg::SEL_HI:sprescale_pkg::SEL_LO];
    end
  end

  // Processor request is a plain AND, so a late enable fires at once
  assign tick_vector_line = flag_q && en_q;

  // Remember the halt request to find its rising edge
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      halt_prev_q <= 1'b0;
    end
    else
    begin
      halt_prev_q <= deep_halt_request;
    end
  end

  // Watchdog hooks; the tap is a counter flop, so it is glitch free
  assign dog_count_clk     = count_q[sprescale_pkg::DOG_TAP];
  assign dog_counter_clear = clear_any && dog_clk_sel;

  // Oscillation wait: from any clear to the wait tap's first fall
  assign stab_fall = bit_fall[sprescale_pkg::STAB_TAP];

  always_comb
  begin
    case (state_q)
      sprescale_pkg::ST_RUN:
      begin
        if (dog_sub_rst)
          state_d = sprescale_pkg::ST_DOG_HOLD;
        else if (clear_any)
          state_d = sprescale_pkg::ST_STAB;
        else
          state_d = sprescale_pkg::ST_RUN;
      end
      sprescale_pkg::ST_STAB:
      begin
        if (dog_sub_rst)
          state_d = sprescale_pkg::ST_DOG_HOLD;
        else if (clear_any)
          state_d = sprescale_pkg::ST_STAB;     // Wait restarts
        else if (stab_fall)
          state_d = sprescale_pkg::ST_RUN;
        else
          state_d = sprescale_pkg::ST_STAB;
      end
      sprescale_pkg::ST_DOG_HOLD:
      begin
        // Reset stays out until the oscillator has settled
        if (clear_any || !stab_fall)
          state_d = sprescale_pkg::ST_DOG_HOLD;
        else
          state_d = sprescale_pkg::ST_RUN;
      end
      default: state_d = sprescale_pkg::ST_STAB;
    endcase
  end

  // Power-on also starts a wait, since the counter was just cleared
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_q <= sprescale_pkg::ST_STAB;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign osc_wait_active = (state_q != sprescale_pkg::ST_RUN);
  assign cpu_reset_out   = (state_q == sprescale_pkg::ST_DOG_HOLD);

  // One-cycle pulse: restart in main clock mode after the hold
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      main_mode_restart <= 1'b0;
    end
    else
    begin
      main_mode_restart <= (state_q == sprescale_pkg::ST_DOG_HOLD)
                        && (state_d == sprescale_pkg::ST_RUN);
    end
  end

  // Events: tick flag sets and wait completion
  assign evt_set[sprescale_pkg::EVT_TICK] = flag_set;
  assign evt_set[sprescale_pkg::EVT_STAB] =
    (state_q != sprescale_pkg::ST_RUN) && (state_d == sprescale_pkg::ST_RUN);

  // Sticky status; a read clears only bits it showed, so a new set wins
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      status_q <= sprescale_pkg::EVT_RST;
    end
    else
    begin
      status_q <= (status_q & ~(rd_status ? rd_taken_q : '0)) | evt_set;
    end
  end

  // Interrupt mask
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      mask_q <= sprescale_pkg::EVT_RST;
    end
    else if (wr_mask)
    begin
      mask_q <= pwdata[sprescale_pkg::EVT_W-1:0];
    end
  end

  assign irq = |(status_q & mask_q);

  // Read mux; reserved bits read zero, clear bit always reads one
  always_comb
  begin
    rdata_d = 32'h0;
    case (paddr)
      sprescale_pkg::ADDR_CTRL:
      begin
        rdata_d[sprescale_pkg::FLAG_BIT] = flag_q;
        rdata_d[sprescale_pkg::EN_BIT]   = en_q;
        rdata_d[sprescale_pkg::SEL_HI:sprescale_pkg::SEL_LO] = sel_q;
        rdata_d[sprescale_pkg::CLR_BIT]  = 1'b1;
      end
      sprescale_pkg::ADDR_STATUS:
        rdata_d[sprescale_pkg::EVT_W-1:0] = status_q;
      sprescale_pkg::ADDR_MASK:
        rdata_d[sprescale_pkg::EVT_W-1:0] = mask_q;
      sprescale_pkg::ADDR_COUNT:
        rdata_d[sprescale_pkg::CNT_W-1:0] = count_q;
      default: rdata_d = 32'h0;
    endcase
  end

  // Read data is captured in the setup cycle and held for the access
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      prdata_q   <= 32'h0;
      rd_taken_q <= sprescale_pkg::EVT_RST;
    end
    else if (setup_ph && !pwrite)
    begin
      prdata_q   <= rdata_d;
      rd_taken_q <= (paddr == sprescale_pkg::ADDR_STATUS)
                  ? status_q : sprescale_pkg::EVT_RST;
    end
  end

  // Checks
  a_flag_sets: assert property (@(posedge sys_clk) disable iff (srst)
    (tap_fall && !main_stop_mode) |=> flag_q)
    else $error("tap fall did not set flag");
  a_enable_irq: assert property (@(posedge sys_clk) disable iff (srst)
    ($rose(en_q) && flag_q) |-> tick_vector_line)
    else $error("late enable gave no request");
  a_flag_keep_one: assert property (@(posedge sys_clk) disable iff (srst)
    (wr_ctrl && pwdata[7] && !flag_set) |=> (flag_q == $past(flag_q)))
    else $error("writing one changed flag");
  a_sw_clear: assert property (@(posedge sys_clk) disable iff (srst)
    sw_clear |=> (count_q == sprescale_pkg::CNT_ZERO))
    else $error("software clear left counter nonzero");
  a_clear_no_flag: assert property (@(posedge sys_clk) disable iff (srst)
    (sw_clear && !flag_q) |=> !flag_q)
    else $error("flag set during clear");
  a_stop_holds: assert property (@(posedge sys_clk) disable iff (srst)
    (main_stop_mode && !flag_q && !(wr_ctrl && pwdata[7])) |=> !flag_q)
    else $error("flag set in main stop");
  a_halt_clear: assert property (@(posedge sys_clk) disable iff (srst)
    halt_rise |=> (count_q == sprescale_pkg::CNT_ZERO))
    else $error("sub-stop entry did not clear");
  a_wait_ends: assert property (@(posedge sys_clk) disable iff (srst)
    (state_q == sprescale_pkg::ST_STAB && stab_fall && !clear_any)
      |=> !osc_wait_active)
    else $error("wait did not end at tap fall");
  a_sel_long: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_q[2] && sel_q[1]) |-> (tap_fall == bit_fall[16]))
    else $error("spare code not on longest tap");
  a_dog_clear: assert property (@(posedge sys_clk) disable iff (srst)
    dog_counter_clear |=> (count_q == sprescale_pkg::CNT_ZERO))
    else $error("dog clear without counter clear");
  a_dog_hold: assert property (@(posedge sys_clk) disable iff (srst)
    dog_sub_rst |=> (cpu_reset_out [*2]))
    else $error("reset not held after dog reset");

endmodule : subclock_interval_prescaler

// *** rtl/sprescale_pkg.sv ***
// Constants shared by the subclock interval prescaler and its counter
package sprescale_pkg;
  // Counter geometry
  localparam int                CNT_W       = 17;
  localparam logic [CNT_W-1:0]  CNT_ZERO    = 17'h00000;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 17'h00001;
  // Register byte addresses
  localparam int                ADDR_W      = 8;
  localparam logic [7:0]        ADDR_CTRL   = 8'h00;
  localparam logic [7:0]        ADDR_STATUS = 8'h04;
  localparam logic [7:0]        ADDR_MASK   = 8'h08;
  localparam logic [7:0]        ADDR_COUNT  = 8'h0c;
  // Control register field positions
  localparam int                FLAG_BIT    = 7;
  localparam int                EN_BIT      = 6;
  localparam int                SEL_HI      = 3;
  localparam int                SEL_LO      = 1;
  localparam int                CLR_BIT     = 0;
  // Control register reset values
  localparam logic              EN_RST      = 1'b0;
  localparam logic [2:0]        SEL_RST     = 3'h0;
  // Counter bits whose falls mark 2^10, 2^13 .. 2^17 subclock periods
  localparam int                TAP_10      = 9;
  localparam int                TAP_13      = 12;
  localparam int                TAP_14      = 13;
  localparam int                TAP_15      = 14;
  localparam int                TAP_16      = 15;
  localparam int                TAP_17      = 16;
  // Watchdog count clock and stabilization wait taps
  localparam int                DOG_TAP     = TAP_14;
  localparam int                STAB_TAP    = TAP_15;
  // Event status bits
  localparam int                EVT_W       = 2;
  localparam int                EVT_TICK    = 0;
  localparam int                EVT_STAB    = 1;
  localparam logic [EVT_W-1:0]  EVT_RST     = 2'h0;
  // Interval select codes
  typedef enum logic [2:0] {
    SEL_P10 = 3'h0,
    SEL_P13 = 3'h1,
    SEL_P14 = 3'h2,
    SEL_P15 = 3'h3,
    SEL_P16 = 3'h4,
    SEL_P17 = 3'h5
  } tap_sel_t;
  // Oscillation wait sequencer states
  typedef enum logic [1:0] {
    ST_RUN      = 2'b00,
    ST_STAB     = 2'b01,
    ST_DOG_HOLD = 2'b10
  } wait_state_t;
endpackage : sprescale_pkg

// *** rtl/subclock_counter.sv ***
// Free-running subclock up-counter with per-bit falling-edge strobes
`timescale 1ns/1ps
module subclock_counter #(
  parameter int W = sprescale_pkg::CNT_W
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic         tick,      // One subclock period elapsed
  input  wire logic         clear,     // Restart from zero
  output logic [W-1:0]      count_q,   // Counter value
  output logic [W-1:0]      bit_fall   // Bit i falls at this edge
);

  // Refuse widths the tap set cannot live in
  if (W < sprescale_pkg::CNT_W)
  begin : g_width_check
    $error("subclock_counter: width below tap range");
  end

  // Count on every tick; any clear wins over the tick
  always_ff @(posedge sys_clk)
  begin
    if (srst || clear)
    begin
      count_q <= '0;
    end
    else if (tick)
    begin
      count_q <= count_q + W'(1);
    end
  end

  // A bit falls when it and all bits below are ones at a tick.
  // A clear in the same cycle swallows the fall.
  for (genvar i = 0; i < W; i++)
  begin : g_fall
    assign bit_fall[i] = tick && !clear && (&count_q[i:0]);
  end

  // Counter advances by one per tick, wrapping to zero
  a_count_adv: assert property (@(posedge sys_clk) disable iff (srst)
    (tick && !clear) |=> (count_q == W'($past(count_q) + W'(1))))
    else $error("counter did not advance by one");

endmodule : subclock_counter

// *** verif/test_subclock_interval_prescaler.sv ***
// Self-checking testbench for the subclock interval prescaler
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
      error_cnt++; \
      $display("Error %s exp %h got %h", nm, ex, got); \
    end \
  end
module test_subclock_interval_prescaler;
  // Expected outcome of one APB transfer, queued by the driver
  typedef struct packed {logic wr; logic err; logic [31:0] d;} note_t;
  localparam logic [7:0] A_CT = sprescale_pkg::ADDR_CTRL;
  localparam logic [7:0] A_ST = sprescale_pkg::ADDR_STATUS;
  localparam logic [7:0] A_MK = sprescale_pkg::ADDR_MASK;
  localparam logic [7:0] A_CN = sprescale_pkg::ADDR_COUNT;
  localparam int         CEIL = 100000;  // Tests need about 80k cycles
  logic        sys_clk = 1'b0;
  logic        srst, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sub_osc_tick, main_stop_mode;
  logic        deep_halt_request, sub_clock_mode, dog_reset_req;
  logic        dog_clk_sel, tick_vector_line, irq, dog_count_clk;
  logic        dog_counter_clear, osc_wait_active, cpu_reset_out;
  logic        main_mode_restart;
  note_t       notes[$];               // Pending APB expectations
  note_t       nt;                     // Note being compared
  int          error_cnt = 0;          // Mismatches seen
  int          tests_run = 0;          // Comparisons made
  int          cyc = 0;                // Cycle count for the timeout
  int          restart_cnt = 0;        // Restart pulses seen
  logic [1:0]  mask_v;                 // Mask value software wrote
  int          n;                      // Random tick count

  subclock_interval_prescaler i_subclock_interval_prescaler (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sub_osc_tick(sub_osc_tick),
    .main_stop_mode(main_stop_mode),
    .deep_halt_request(deep_halt_request),
    .sub_clock_mode(sub_clock_mode), .dog_reset_req(dog_reset_req),
    .dog_clk_sel(dog_clk_sel), .tick_vector_line(tick_vector_line),
    .irq(irq), .dog_count_clk(dog_count_clk),
    .dog_counter_clear(dog_counter_clear),
    .osc_wait_active(osc_wait_active), .cpu_reset_out(cpu_reset_out),
    .main_mode_restart(main_mode_restart)
  );

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  // Closing report, reached from the main sequence or the timeout
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Control register image: clear bit always reads one
  function automatic logic [31:0] cv(logic f, logic e, logic [2:0] s);
    return {24'h0, f, e, 2'b00, s, 1'b1};
  endfunction : cv

  // One APB transfer; the note is queued for the monitor
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] ex,
                     input logic er);
    notes.push_back('{wr, er, ex});
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Hold the request until pready is seen; the hang guard bounds it
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0, ex, 1'b0);
  endtask : rd

  // Subclock ticks: exactly k edges see the tick high
  task automatic ticks(input int k);
    @(posedge sys_clk);
    sub_osc_tick <= 1'b1;
    repeat (k - 1) @(posedge sys_clk);
    @(posedge sys_clk);
    sub_osc_tick <= 1'b0;
  endtask : ticks

  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : idle

  // Clear, run one tick short of the tap period, then one more tick
  task automatic tap_run(input logic [2:0] sel, input int k);
    int         c;
    logic [1:0] st;
    c  = (1 << k) - 1;
    st = {1'(k == 15), 1'b1};
    dog_clk_sel <= 1'($urandom % 2);
    wr(A_CT, {28'h0, sel, 1'b0});
    ticks(c);
    idle(2);
    `CHK("dog_count_clk", c[13], dog_count_clk)
    `CHK("osc_wait_active", 1'b1, osc_wait_active)
    rd(A_CT, cv(1'b0, 1'b0, sel));
    ticks(1);
    idle(2);
    `CHK("osc_wait_active", 1'(k != 15), osc_wait_active)
    rd(A_CT, cv(1'b1, 1'b0, sel));
    `CHK("irq", |(st & mask_v), irq)
    rd(A_ST, {30'h0, st});
    // The read clears status on its access edge; look one edge later
    idle(1);
    `CHK("irq", 1'b0, irq)
  endtask : tap_run

  // Monitor: takes the oldest note at each completed transfer
  always @(posedge sys_clk)
  begin
    if (main_mode_restart === 1'b1)
      restart_cnt++;
    if (psel && penable && pready)
    begin
      nt = notes.pop_front();
      if (!nt.wr)
        `CHK("prdata", nt.d, prdata)
      `CHK("pslverr", nt.err, pslverr)
      // A software clear must reach the watchdog when it is selected
      if (pwrite && paddr == A_CT && !pwdata[0])
        `CHK("dog_counter_clear", dog_clk_sel, dog_counter_clear)
    end
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == CEIL)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // Main sequence
  initial
  begin
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sub_osc_tick, main_stop_mode, deep_halt_request} = '0;
    {sub_clock_mode, dog_reset_req, dog_clk_sel} = '0;
    mask_v = 2'h0;
    void'($urandom(68));
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    // Reset values, and an unmapped place that must be refused
    rd(A_CT, cv(1'b0, 1'b0, 3'h0));
    rd(A_CN, 32'h0);
    rd(A_MK, 32'h0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'hff, 32'h0, 1'b1);
    `CHK("osc_wait_active", 1'b1, osc_wait_active)
    `CHK("cpu_reset_out", 1'b0, cpu_reset_out)
    // Counting and software clear
    n = 1 + ($urandom % 300);
    ticks(n);
    idle(1);
    rd(A_CN, 32'(n));
    wr(A_CT, 32'h0);
    rd(A_CN, 32'h0);
    // Every select code reads back as written
    for (int s = 0; s < 8; s++)
    begin
      wr(A_CT, {28'h0, 3'(s), 1'b1});
      rd(A_CT, cv(1'b0, 1'b0, 3'(s)));
    end
    mask_v = 2'h3;
    wr(A_MK, 32'h3);
    rd(A_MK, 32'h3);
    tap_run(3'h0, 10);
    tap_run(3'h1, 13);
    tap_run(3'h3, 15);
    // Enable while the flag is set requests at once; one is ignored
    wr(A_CT, cv(1'b1, 1'b1, 3'h0));
    // The enable lands on the access edge; sample after it settles
    idle(1);
    `CHK("tick_vector_line", 1'b1, tick_vector_line)
    rd(A_CT, cv(1'b1, 1'b1, 3'h0));
    wr(A_CT, cv(1'b0, 1'b1, 3'h0));
    idle(1);
    `CHK("tick_vector_line", 1'b0, tick_vector_line)
    // Clear lands on the very edge whose tick would make the tap fall
    wr(A_CT, 32'h40);
    ticks(1021);
    @(posedge sys_clk);
    sub_osc_tick <= 1'b1;
    wr(A_CT, 32'h40);
    sub_osc_tick <= 1'b0;
    idle(2);
    rd(A_CT, cv(1'b0, 1'b1, 3'h0));
    // Main stop: counting goes on, flag stays clear
    main_stop_mode <= 1'b1;
    wr(A_CT, 32'h40);
    ticks(1024);
    idle(2);
    rd(A_CN, 32'd1024);
    rd(A_CT, cv(1'b0, 1'b1, 3'h0));
    main_stop_mode <= 1'b0;
    // Sub-stop entry clears the counter; interrupt disabled first
    wr(A_CT, 32'h01);
    deep_halt_request <= 1'b1;
    idle(2);
    rd(A_CN, 32'h0);
    deep_halt_request <= 1'b0;
    // Masked event: status set, no interrupt
    mask_v = 2'h0;
    wr(A_MK, 32'h0);
    wr(A_CT, 32'h0);
    ticks(1024);
    idle(2);
    `CHK("irq", 1'b0, irq)
    rd(A_ST, 32'h1);
    rd(A_ST, 32'h0);
    // Watchdog reset in subclock mode holds reset through the wait
    sub_clock_mode <= 1'b1;
    dog_clk_sel    <= 1'b1;
    @(posedge sys_clk);
    dog_reset_req <= 1'b1;
    #1;
    `CHK("dog_counter_clear", 1'b1, dog_counter_clear)
    @(posedge sys_clk);
    dog_reset_req <= 1'b0;
    #1;
    `CHK("cpu_reset_out", 1'b1, cpu_reset_out)
    ticks(32767);
    idle(2);
    `CHK("cpu_reset_out", 1'b1, cpu_reset_out)
    ticks(1);
    idle(2);
    `CHK("cpu_reset_out", 1'b0, cpu_reset_out)
    `CHK("osc_wait_active", 1'b0, osc_wait_active)
    `CHK("restart_cnt", 1, restart_cnt)
    print_verdict();
  end
endmodule : test_subclock_interval_prescaler
